//--- pkg/mrc_defs.svh
// constants of the monitor, alarm and reset control block
// assumes a 125 MHz system clock; included by the top module only
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH
`define MRC_CLK_NS 8
`define MRC_PULSE_US 125
`define MRC_DLY1_US 17500
`define MRC_DLY2_US 22500
`define MRC_DLY3_US 27000
`define MRC_DLY4_US 45000
`define MRC_US2CYC(t) (((t) * 1000) / `MRC_CLK_NS)
`define MRC_CNT_W 23
`define MRC_NCH 5
`define MRC_LAST_CH 3'h4
`define MRC_PAGE_A2 2'h1
`define MRC_PAGE_A6 2'h3
`define MRC_AMASK_LO 8'hf8
`define MRC_AMASK_HI 8'hf9
`define MRC_WMASK_LO 8'hfa
`define MRC_WMASK_HI 8'hfb
`define MRC_RST_FIELD 8'hff
`define MRC_RESULT_BASE 8'h60
`define MRC_ASTAT_LO 8'h70
`define MRC_ASTAT_HI 8'h71
`define MRC_WSTAT_LO 8'h74
`define MRC_WSTAT_HI 8'h75
`define MRC_AUX_CFG 8'h00
`define MRC_ADDR_CFG 8'h02
`define MRC_PIN_CFG 8'h13
`define MRC_FAULT_CFG 8'h19
`define MRC_MULTI_CFG 8'h1a
`define MRC_MASK_HI_RST 8'h40
`define MRC_ADDR_CFG_RST 8'ha2
`define MRC_PULSE_CODE 3'h7
`define MRC_DLY_DEFAULT 3'h2
`endif

//--- pkg/mrc_pkg.sv
// types of the monitor, alarm and reset control block
// shared by the top module and the bench
package mrc_pkg;
  typedef logic [2:0] mrc_sel_t;
  typedef enum logic [1:0] {MRC_SQ_START = 2'b01, MRC_SQ_WAIT = 2'b10} mrc_seq_t;
  typedef enum logic [2:0]
  {
    MRC_RS_IDLE = 3'b001,
    MRC_RS_PULSE = 3'b010,
    MRC_RS_HOLD = 3'b100
  } mrc_rst_t;
endpackage

//--- hw/mrc_top.sv
// monitor sequencing, alarm flags, smbus slave, address select, reset pulse pin
// assumes pins (scl, sda, straps, tx disable) are asynchronous; adc on clk
`timescale 1ns/1ps
`include "mrc_defs.svh"

// Operation
// - five channels sampled in order, committed per pass
// - aux select field picks supply channel source in oem mode
// - violations set flags and unmasked raise interrupt
// - mask bit one blocks interrupt, flag still sets
// - alarm mask bytes 248 and 249 layout
// - warning mask bytes 250 and 251 same layout
// - masks reset zero except receive power low
// - fault config bits 6,7 add alarms, warnings
// - fault path uses the same source masks
// - flags latch until status read or toggle
// - bit 5 makes warnings follow live condition
// - bit 4 makes alarms follow live condition
// - multi-part mode takes address bits from straps
// - factory address A0, multi-part mode off
// - single mode address from config bits 7-4
// - pin config bit 7 picks output or reset
// - reset field resets 000, pin driven low after reset (general mode, bit 6 low)
// - writing 111 pulls pin low 125 us
// - field clears after selected delay past release
// - outside reset mode field drives nothing
module mrc_top #(
  parameter int unsigned PULSE_CYCLES = `MRC_US2CYC(`MRC_PULSE_US),
  parameter int unsigned DLY1_CYCLES = `MRC_US2CYC(`MRC_DLY1_US),
  parameter int unsigned DLY2_CYCLES = `MRC_US2CYC(`MRC_DLY2_US),
  parameter int unsigned DLY3_CYCLES = `MRC_US2CYC(`MRC_DLY3_US),
  parameter int unsigned DLY4_CYCLES = `MRC_US2CYC(`MRC_DLY4_US)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_a3,
  input wire logic strap_a4,
  input wire logic transmit_disable_in,
  input wire logic oem_mode,
  output logic adc_start,
  output logic [2:0] adc_chan,
  output mrc_pkg::mrc_sel_t aux_channel_select,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  input wire logic [79:0] alarm_high_thr,
  input wire logic [79:0] alarm_low_thr,
  input wire logic [79:0] warn_high_thr,
  input wire logic [79:0] warn_low_thr,
  output logic interrupt_out,
  output logic transmit_fault_out,
  output logic reset_gpo_out,
  output logic reset_gpo_oe
);
  import mrc_pkg::*;

  // ****************************************
  // registers and pin synchronisers
  // ****************************************
  logic [7:0] amask_lo, amask_hi, wmask_lo, wmask_hi;
  logic [2:0] aux_source_config, reset_pulse_field;
  logic [7:0] address_delay_config, pin_function_config, fault_latch_config, multi_part_config;
  logic [9:0] aflag, wflag, acond, wcond, aclr, wclr;
  logic [15:0] staged [`MRC_NCH];
  logic [15:0] result [`MRC_NCH];
  logic [3:0] s1, s2;
  logic scl_d, sda_d, txd_d, commit, field_clr;
  logic txd_s1, txd_s2;
  logic wr_stb, rd_stb;
  logic [1:0] wr_page, rd_page;
  logic [7:0] wr_ptr, wr_data, rd_ptr;

  // the first stage feeds only the second; edge detection looks at s2 only
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      s1 <= 4'h3;
      s2 <= 4'h3;
    end
    else
    begin
      s1 <= {strap_a4, strap_a3, sda_in, scl_in};
      s2 <= s1;
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      txd_d <= 1'b0;
    end
    else
    begin
      scl_d <= s2[0];
      sda_d <= s2[1];
      txd_d <= txd_s2;
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      txd_s1 <= 1'b0;
      txd_s2 <= 1'b0;
    end
    else
    begin
      txd_s1 <= transmit_disable_in;
      txd_s2 <= txd_s1;
    end

  wire txd_toggle = txd_s2 ^ txd_d;
  wire scl_rise = s2[0] & ~scl_d;
  wire scl_fall = ~s2[0] & scl_d;
  wire bus_start = s2[0] & scl_d & sda_d & ~s2[1];
  wire bus_stop = s2[0] & scl_d & ~sda_d & s2[1];

  // ****************************************
  // configuration writes
  // ****************************************
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      amask_lo <= 8'h00;
      amask_hi <= `MRC_MASK_HI_RST;
      wmask_lo <= 8'h00;
      wmask_hi <= `MRC_MASK_HI_RST;
      aux_source_config <= 3'h0;
      address_delay_config <= `MRC_ADDR_CFG_RST;
      pin_function_config <= 8'h00;
      fault_latch_config <= 8'h00;
      multi_part_config <= 8'h00;
    end
    else if (wr_stb && wr_page == `MRC_PAGE_A2)
    begin
      case (wr_ptr)
        `MRC_AMASK_LO: amask_lo <= wr_data;
        `MRC_AMASK_HI: amask_hi <= {wr_data[7:6], 6'h00};
        `MRC_WMASK_LO: wmask_lo <= wr_data;
        `MRC_WMASK_HI: wmask_hi <= {wr_data[7:6], 6'h00};
        default: ;
      endcase
    end
    else if (wr_stb && wr_page == `MRC_PAGE_A6)
    begin
      case (wr_ptr)
        `MRC_AUX_CFG: aux_source_config <= wr_data[2:0];
        `MRC_ADDR_CFG: address_delay_config <= wr_data;
        `MRC_PIN_CFG: pin_function_config <= wr_data;
        `MRC_FAULT_CFG: fault_latch_config <= wr_data;
        `MRC_MULTI_CFG: multi_part_config <= wr_data;
        default: ;
      endcase
    end

  // ****************************************
  // conversion sequencer
  // ****************************************
  mrc_seq_t seq;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      seq <= MRC_SQ_START;
      adc_chan <= 3'h0;
      adc_start <= 1'b0;
      commit <= 1'b0;
    end
    else
    begin
      adc_start <= 1'b0;
      commit <= 1'b0;
      case (seq)
        MRC_SQ_START:
        begin
          adc_start <= 1'b1;
          seq <= MRC_SQ_WAIT;
        end
        MRC_SQ_WAIT:
          if (adc_done)
          begin
            seq <= MRC_SQ_START;
            commit <= (adc_chan == `MRC_LAST_CH);
            adc_chan <= (adc_chan == `MRC_LAST_CH) ? 3'h0 : adc_chan + 3'h1;
          end
        default: seq <= MRC_SQ_START;
      endcase
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      aux_channel_select <= 3'h0;
    else
      aux_channel_select <= oem_mode ? aux_source_config : 3'h0;

  // results are staged during a pass and all committed at its end
  genvar g;
  generate
    for (g = 0; g < `MRC_NCH; g++)
    begin : g_ch
      always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
          staged[g] <= 16'h0000;
          result[g] <= 16'h0000;
        end
        else
        begin
          if (seq == MRC_SQ_WAIT && adc_done && adc_chan == 3'(g))
            staged[g] <= adc_data;
          if (commit)
            result[g] <= staged[g];
        end
      // compared against the values being committed, once per pass
      assign acond[9-2*g] = staged[g] > alarm_high_thr[16*g +: 16];
      assign acond[8-2*g] = staged[g] < alarm_low_thr[16*g +: 16];
      assign wcond[9-2*g] = staged[g] > warn_high_thr[16*g +: 16];
      assign wcond[8-2*g] = staged[g] < warn_low_thr[16*g +: 16];
    end
  endgenerate

  // ****************************************
  // alarm and warning flags
  // ****************************************
  wire [9:0] amask = {amask_lo, amask_hi[7:6]};
  wire [9:0] wmask = {wmask_lo, wmask_hi[7:6]};
  wire rd_a2 = rd_stb && rd_page == `MRC_PAGE_A2;
  assign aclr = {{8{rd_a2 && rd_ptr == `MRC_ASTAT_LO}}, {2{rd_a2 && rd_ptr == `MRC_ASTAT_HI}}}
    | {10{txd_toggle}};
  assign wclr = {{8{rd_a2 && rd_ptr == `MRC_WSTAT_LO}}, {2{rd_a2 && rd_ptr == `MRC_WSTAT_HI}}}
    | {10{txd_toggle}};

  // a new violation in the clearing cycle survives the clear
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      aflag <= 10'h000;
      wflag <= 10'h000;
    end
    else
    begin
      if (commit && fault_latch_config[4])
        aflag <= acond & ~(aclr & ~acond);
      else
        aflag <= (aflag & ~aclr) | ({10{commit}} & acond);
      if (commit && fault_latch_config[5])
        wflag <= wcond & ~(wclr & ~wcond);
      else
        wflag <= (wflag & ~wclr) | ({10{commit}} & wcond);
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      interrupt_out <= 1'b0;
      transmit_fault_out <= 1'b0;
    end
    else
    begin
      interrupt_out <= |(aflag & ~amask) | |(wflag & ~wmask);
      transmit_fault_out <= (fault_latch_config[6] & |(aflag & ~amask))
        | (fault_latch_config[7] & |(wflag & ~wmask));
    end

  // ****************************************
  // reset pulse pin
  // ****************************************
  mrc_rst_t rs;
  logic [`MRC_CNT_W-1:0] rcnt, dly_cyc;
  wire rmode = pin_function_config[7];
  always_comb
    case (address_delay_config[2:0])
      3'h0: dly_cyc = '0;
      3'h1: dly_cyc = `MRC_CNT_W'(DLY1_CYCLES);
      3'h3: dly_cyc = `MRC_CNT_W'(DLY3_CYCLES);
      3'h4: dly_cyc = `MRC_CNT_W'(DLY4_CYCLES);
      default: dly_cyc = `MRC_CNT_W'(DLY2_CYCLES);
    endcase
  wire pulse_end = rs == MRC_RS_PULSE && rcnt == `MRC_CNT_W'(PULSE_CYCLES - 1);
  assign field_clr = (pulse_end && dly_cyc == '0)
    || (rs == MRC_RS_HOLD && rcnt == dly_cyc - `MRC_CNT_W'(1));

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rs <= MRC_RS_IDLE;
      rcnt <= '0;
    end
    else if (!rmode)
    begin
      rs <= MRC_RS_IDLE;
      rcnt <= '0;
    end
    else
      case (rs)
        MRC_RS_IDLE:
          if (reset_pulse_field == `MRC_PULSE_CODE)
            rs <= MRC_RS_PULSE;
        MRC_RS_PULSE:
        begin
          rcnt <= pulse_end ? '0 : rcnt + `MRC_CNT_W'(1);
          if (pulse_end)
            rs <= field_clr ? MRC_RS_IDLE : MRC_RS_HOLD;
        end
        MRC_RS_HOLD:
        begin
          rcnt <= rcnt + `MRC_CNT_W'(1);
          if (field_clr)
          begin
            rs <= MRC_RS_IDLE;
            rcnt <= '0;
          end
        end
        default: rs <= MRC_RS_IDLE;
      endcase

  // a host write in the clearing cycle wins: it is newer than the clear
  always_ff @(posedge clk or posedge rst)
    if (rst)
      reset_pulse_field <= 3'h0;
    else if (wr_stb && wr_page == `MRC_PAGE_A2 && wr_ptr == `MRC_RST_FIELD)
      reset_pulse_field <= wr_data[2:0];
    else if (field_clr)
      reset_pulse_field <= 3'h0;

  // general output mode drives low for config bit 6 low, else releases
  assign reset_gpo_out = 1'b0;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      reset_gpo_oe <= 1'b0;
    else
      reset_gpo_oe <= rmode ? (rs == MRC_RS_PULSE) : ~pin_function_config[6];

  // ****************************************
  // smbus slave
  // ****************************************
  logic active, first, second, rw, nacked, ack_drv;
  logic [3:0] bitcnt;
  logic [7:0] sh, tx, ptr;
  logic [1:0] page;
  logic [7:0] rd_byte;
  wire [7:3] my_addr = multi_part_config[3] ? {address_delay_config[7:5], s2[3], s2[2]}
    : {address_delay_config[7:4], 1'b0};
  wire addr_hit = sh[7:3] == my_addr && sh[1]; // page 01 or 11

  always_comb
  begin
    rd_byte = 8'h00;
    if (page == `MRC_PAGE_A2)
      case (ptr)
        `MRC_AMASK_LO: rd_byte = amask_lo;
        `MRC_AMASK_HI: rd_byte = amask_hi;
        `MRC_WMASK_LO: rd_byte = wmask_lo;
        `MRC_WMASK_HI: rd_byte = wmask_hi;
        `MRC_RST_FIELD: rd_byte = {5'h00, reset_pulse_field};
        `MRC_ASTAT_LO: rd_byte = aflag[9:2];
        `MRC_ASTAT_HI: rd_byte = {aflag[1:0], 6'h00};
        `MRC_WSTAT_LO: rd_byte = wflag[9:2];
        `MRC_WSTAT_HI: rd_byte = {wflag[1:0], 6'h00};
        default:
          for (int i = 0; i < `MRC_NCH; i++)
          begin
            if (ptr == `MRC_RESULT_BASE + 8'(2 * i))
              rd_byte = result[i][15:8];
            if (ptr == `MRC_RESULT_BASE + 8'(2 * i + 1))
              rd_byte = result[i][7:0];
          end
      endcase
    else if (page == `MRC_PAGE_A6)
      case (ptr)
        `MRC_AUX_CFG: rd_byte = {5'h00, aux_source_config};
        `MRC_ADDR_CFG: rd_byte = address_delay_config;
        `MRC_PIN_CFG: rd_byte = pin_function_config;
        `MRC_FAULT_CFG: rd_byte = fault_latch_config;
        `MRC_MULTI_CFG: rd_byte = multi_part_config;
        default: rd_byte = 8'h00;
      endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {active, first, second, rw, nacked, ack_drv, wr_stb, rd_stb} <= 8'h00;
      bitcnt <= 4'h0;
      {sh, tx, ptr, wr_ptr, wr_data, rd_ptr} <= 48'h0000_0000_0000;
      {page, wr_page, rd_page} <= 6'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (bus_start)
      begin
        {active, first, nacked, ack_drv} <= 4'b1100;
        // the start's own scl fall wraps this to 0, so it is not counted as a bit
        bitcnt <= 4'hf;
      end
      else if (bus_stop)
        {active, ack_drv} <= 2'b00;
      else if (active)
      begin
        if (scl_rise && bitcnt < 4'h8)
          sh <= {sh[6:0], s2[1]};
        if (scl_rise && bitcnt == 4'h8 && rw && !first)
          nacked <= s2[1];
        if (scl_fall && bitcnt == 4'h7)
        begin
          bitcnt <= 4'h8;
          if (first)
          begin
            active <= addr_hit;
            ack_drv <= addr_hit;
            {first, rw, second} <= {1'b0, sh[0], ~sh[0]};
            page <= sh[2:1];
            nacked <= 1'b0;
          end
          else if (second)
          begin
            {ptr, second, ack_drv} <= {sh, 2'b01};
          end
          else if (!rw)
          begin
            {wr_stb, wr_page, wr_ptr, wr_data, ack_drv} <= {1'b1, page, ptr, sh, 1'b1};
            ptr <= ptr + 8'h01;
          end
        end
        else if (scl_fall && bitcnt == 4'h8)
        begin
          bitcnt <= 4'h0;
          ack_drv <= 1'b0;
          if (rw && !nacked)
          begin
            {tx, rd_stb, rd_page, rd_ptr} <= {rd_byte, 1'b1, page, ptr};
            ptr <= ptr + 8'h01;
          end
        end
        else if (scl_fall)
        begin
          bitcnt <= bitcnt + 4'h1;
          tx <= {tx[6:0], 1'b0};
        end
      end
    end

  assign sda_out = 1'b0;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      sda_oe <= 1'b0;
    else
      sda_oe <= active && (ack_drv || (rw && !first && !nacked && bitcnt < 4'h8 && !tx[7]));

  // ****************************************
  // checks
  // ****************************************
  sequence pulse_begin_s;
    rs == MRC_RS_IDLE && rmode && reset_pulse_field == `MRC_PULSE_CODE;
  endsequence
  sequence pulse_enter_s;
    pulse_begin_s ##1 rs == MRC_RS_PULSE;
  endsequence
  pass_commit_a: assert property (@(posedge clk) disable iff (rst)
    commit |-> $past(adc_done && adc_chan == `MRC_LAST_CH)) else $error("commit mid pass");
  aux_route_a: assert property (@(posedge clk) disable iff (rst)
    oem_mode |=> aux_channel_select == $past(aux_source_config)) else $error("aux select");
  int_gate_a: assert property (@(posedge clk) disable iff (rst)
    ##1 interrupt_out == $past(|(aflag & ~amask) | |(wflag & ~wmask))) else $error("int mask");
  mask_layout_a: assert property (@(posedge clk) disable iff (rst)
    wr_stb && wr_page == `MRC_PAGE_A2 && wr_ptr == `MRC_AMASK_HI
    |=> amask_hi == {$past(wr_data[7:6]), 6'h00}) else $error("mask layout");
  fault_src_a: assert property (@(posedge clk) disable iff (rst)
    !fault_latch_config[6] && !fault_latch_config[7] |=> !transmit_fault_out)
    else $error("fault source");
  latch_hold_a: assert property (@(posedge clk) disable iff (rst)
    !fault_latch_config[4] && aclr == 10'h000 |=> (aflag & $past(aflag)) == $past(aflag))
    else $error("alarm not latched");
  warn_follow_a: assert property (@(posedge clk) disable iff (rst)
    commit && fault_latch_config[5] && wclr == 10'h000 |=> wflag == $past(wcond))
    else $error("warn follow");
  alarm_follow_a: assert property (@(posedge clk) disable iff (rst)
    commit && fault_latch_config[4] && aclr == 10'h000 |=> aflag == $past(acond))
    else $error("alarm follow");
  pulse_len_a: assert property (@(posedge clk) disable iff (rst)
    rs == MRC_RS_PULSE && rmode ##1 rs != MRC_RS_PULSE && rmode
    |-> $past(rcnt) == `MRC_CNT_W'(PULSE_CYCLES - 1)) else $error("pulse length");
  pulse_drive_a: assert property (@(posedge clk) disable iff (rst)
    pulse_enter_s |=> reset_gpo_oe) else $error("pulse not driven");
  pin_mode_a: assert property (@(posedge clk) disable iff (rst)
    rmode |=> reset_gpo_oe == $past(rs == MRC_RS_PULSE)) else $error("reset pin drive");
endmodule

//--- test/mrc_host_model.sv
// host side of the smbus: a master that drives scl and an open-drain sda
// assumes the device pulls sda low through sda_oe and that the line has a pull-up
`timescale 1ns/1ps
module mrc_host_model
(
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  output logic line
);
  // released line floats to the pull-up level
  assign line = sda & ~sda_oe;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge clk);
  endtask
  // sda moves 3 clk after scl falls so no false start or stop is seen
  task automatic start();
    hp(3);
    sda = 1'b1;
    hp(7);
    scl = 1'b1;
    hp(10);
    sda = 1'b0;
    hp(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    hp(3);
    sda = 1'b0;
    hp(7);
    scl = 1'b1;
    hp(10);
    sda = 1'b1;
    hp(10);
  endtask
  task automatic bitx(input logic b, output logic r);
    hp(3);
    sda = b;
    hp(7);
    scl = 1'b1;
    hp(10);
    r = line;
    scl = 1'b0;
  endtask
  // msb first, then the ack slot with sda released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // address and mode are changed by ordinary writes, also at a shared address
  task automatic wr(input logic [7:0] dev, ptr, dat, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer(dev, q, a0);
    xfer(ptr, q, a1);
    xfer(dat, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // single byte read, the last byte is refused by the master
  task automatic rd(input logic [7:0] dev, ptr, output logic [7:0] dat, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    xfer(dev, q, a0);
    xfer(ptr, q, a1);
    start();
    xfer(dev | 8'h01, q, a2);
    xfer(8'hff, dat, a3);
    stop();
    ok = a0 & a1 & a2 & ~a3;
  endtask
endmodule

//--- test/tb_top.sv
// bench of the monitor, alarm and reset control block, with an adc model
// assumes mrc_pkg and the host model are compiled before it
`timescale 1ns/1ps
module tb_top;
  import mrc_pkg::*;
  localparam int PW = 20;
  localparam int D[8] = '{0, 2000, 2500, 3000, 3500, 2500, 2500, 2500};
  localparam logic [79:0] AH = {5{16'hc000}};
  localparam logic [79:0] AL = {5{16'h1000}};
  localparam logic [79:0] WH = {5{16'h8000}};
  localparam logic [79:0] WL = {5{16'h2000}};
  logic clk, rst, scl, sda, line, strap_a3, strap_a4, txd, oem, adc_done;
  logic sda_oe, adc_start, irq, fault, gpo_oe, ok;
  logic [2:0] adc_chan;
  mrc_sel_t aux;
  logic [15:0] adc_data, am, wm, ca, cw;
  logic [15:0] val[5];
  logic [7:0] fc, q;
  int fails, checked, seed, cyc, cd, ch, exp_ch, hi_cnt, plen, r;
  mrc_host_model mrc_host_model_i (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .line(line));
  mrc_top #(.PULSE_CYCLES(PW), .DLY1_CYCLES(2000), .DLY2_CYCLES(2500), .DLY3_CYCLES(3000),
    .DLY4_CYCLES(3500)) mrc_top_i (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(line),
    .sda_out(), .sda_oe(sda_oe), .strap_a3(strap_a3), .strap_a4(strap_a4),
    .transmit_disable_in(txd), .oem_mode(oem), .adc_start(adc_start), .adc_chan(adc_chan),
    .aux_channel_select(aux), .adc_done(adc_done), .adc_data(adc_data),
    .alarm_high_thr(AH), .alarm_low_thr(AL), .warn_high_thr(WH), .warn_low_thr(WL),
    .interrupt_out(irq), .transmit_fault_out(fault), .reset_gpo_out(),
    .reset_gpo_oe(gpo_oe));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      fails++;
      conclude();
    end
  end
  // **********************************
  // adc model and pin monitor
  // **********************************
  always @(negedge clk)
  begin
    adc_done = 1'b0;
    if (rst)
    begin
      exp_ch = 0;
      cd = 0;
    end
    else if (adc_start === 1'b1)
    begin
      cmp(16'(adc_chan), 16'(exp_ch), "channel order");
      exp_ch = (exp_ch + 1) % 5;
      ch = adc_chan;
      cd = 4;
    end
    else if (cd > 0)
    begin
      cd--;
      adc_done = (cd == 0);
      adc_data = val[ch];
    end
  end
  always @(negedge clk)
    if (gpo_oe === 1'b1)
      hi_cnt++;
    else if (hi_cnt != 0)
    begin
      plen = hi_cnt;
      hi_cnt = 0;
    end
  // **********************************
  // helpers
  // **********************************
  function automatic logic [15:0] cond(input logic [79:0] hi, lo);
    logic [15:0] c;
    c = 16'h0000;
    for (int n = 0; n < 5; n++)
    begin
      c[15 - 2 * n] = val[n] > hi[16 * n +: 16];
      c[14 - 2 * n] = val[n] < lo[16 * n +: 16];
    end
    return c;
  endfunction
  task automatic cmp(input logic [15:0] got, exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] dev, ptr, exp, input string m);
    mrc_host_model_i.rd(dev, ptr, q, ok);
    cmp({7'h00, ok, q}, {8'h01, exp}, m);
  endtask
  task automatic wrc(input logic [7:0] dev, ptr, dat);
    mrc_host_model_i.wr(dev, ptr, dat, ok);
    cmp(16'(ok), 16'h0001, "write ack");
  endtask
  task automatic chk_out(input logic [15:0] a, w);
    cmp(16'(|(a & ~am) | |(w & ~wm)), 16'(irq), "interrupt");
    cmp(16'(fc[6] & |(a & ~am) | fc[7] & |(w & ~wm)), 16'(fault), "fault");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // **********************************
  // main sequence
  // **********************************
  initial
  begin
    seed = 82075;
    rst = 1'b1;
    strap_a3 = 1'b0;
    strap_a4 = 1'b1;
    txd = 1'b0;
    oem = 1'b1;
    adc_done = 1'b0;
    adc_data = 16'h0000;
    for (int n = 0; n < 5; n++)
      val[n] = 16'h5000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 4; i++)
      rdc(8'ha2, 8'hf8 + 8'(i), i[0] ? 8'h40 : 8'h00, "mask reset");
    rdc(8'ha2, 8'hff, 8'h00, "pulse field reset");
    rdc(8'ha6, 8'h55, 8'h00, "unmapped");
    for (int c = 0; c < 7; c++)
    begin
      oem = 1'($random(seed));
      wrc(8'ha6, 8'h00, 8'(c));
      cmp(16'(aux), oem ? 16'(c) : 16'h0000, "aux select");
    end
    for (int k = 0; k < 4; k++)
    begin
      for (int n = 0; n < 5; n++)
      begin
        r = $random(seed);
        val[n] = (r[1:0] != 2'b00) ? 16'h5000 : r[23:8];
      end
      am = 16'($random(seed));
      wm = 16'($random(seed));
      fc = 8'($random(seed)) & 8'hf0;
      wrc(8'ha2, 8'hf8, am[15:8]);
      wrc(8'ha2, 8'hf9, am[7:0]);
      wrc(8'ha2, 8'hfa, wm[15:8]);
      wrc(8'ha2, 8'hfb, wm[7:0]);
      wrc(8'ha6, 8'h19, fc);
      am = am & 16'hffc0;
      wm = wm & 16'hffc0;
      rdc(8'ha2, 8'hf9, am[7:0], "alarm mask hi");
      rdc(8'ha2, 8'hfb, wm[7:0], "warn mask hi");
      ca = cond(AH, AL);
      cw = cond(WH, WL);
      txd = ~txd;
      repeat (150) @(negedge clk);
      chk_out(ca, cw);
      rdc(8'ha2, 8'h60 + 8'(2 * k), val[k][15:8], "result");
      for (int n = 0; n < 5; n++)
        val[n] = 16'h5000;
      repeat (150) @(negedge clk);
      ca = fc[4] ? 16'h0000 : ca;
      cw = fc[5] ? 16'h0000 : cw;
      chk_out(ca, cw);
      rdc(8'ha2, 8'h70, ca[15:8], "alarm status lo");
      rdc(8'ha2, 8'h71, ca[7:0], "alarm status hi");
      rdc(8'ha2, 8'h74, cw[15:8], "warn status lo");
      rdc(8'ha2, 8'h75, cw[7:0], "warn status hi");
    end
    wrc(8'ha6, 8'h13, 8'h00);
    cmp(16'(gpo_oe), 16'h0001, "general low");
    wrc(8'ha6, 8'h13, 8'h40);
    wrc(8'ha2, 8'hff, 8'h07);
    repeat (100) @(negedge clk);
    cmp(16'(gpo_oe), 16'h0000, "general high");
    wrc(8'ha2, 8'hff, 8'h00);
    wrc(8'ha6, 8'h13, 8'h80);
    cmp(16'(gpo_oe), 16'h0000, "reset idle");
    for (int c = 0; c < 8; c++)
    begin
      wrc(8'ha6, 8'h02, 8'ha0 | 8'(c));
      plen = 0;
      wrc(8'ha2, 8'hff, 8'h07);
      repeat (50) @(negedge clk);
      cmp(16'(plen), 16'(PW), "pulse width");
      rdc(8'ha2, 8'hff, (c == 0) ? 8'h00 : 8'h07, "field held");
      repeat (D[c]) @(negedge clk);
      rdc(8'ha2, 8'hff, 8'h00, "field cleared");
    end
    wrc(8'ha6, 8'h1a, 8'h08);
    rdc(8'hb2, 8'hff, 8'h00, "strap address");
    mrc_host_model_i.rd(8'ha2, 8'hff, q, ok);
    cmp(16'(ok), 16'h0000, "old address");
    wrc(8'hb6, 8'h02, 8'hc2);
    wrc(8'hd6, 8'h1a, 8'h00);
    rdc(8'hc2, 8'hff, 8'h00, "single address");
    conclude();
  end
endmodule
